//--- core/dsl_pkg.sv
package dsl_pkg;

  // bus and register map
  localparam int          AXI_AW          = 8;
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  localparam logic [7:0]  REG_IRQ_STATUS  = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK    = 8'h0C;
  localparam logic [7:0]  REG_LOOP_ADDR   = 8'h10;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // control register fields
  localparam int CTRL_FAULT_CMD   = 0;
  localparam int CTRL_BYP_FORCE_A = 1;
  localparam int CTRL_BYP_FORCE_B = 2;
  localparam int CTRL_BYP_CLR_A   = 3;
  localparam int CTRL_BYP_CLR_B   = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // interrupt bit positions
  localparam int IRQ_BYPASS_A   = 0;
  localparam int IRQ_BYPASS_B   = 1;
  localparam int IRQ_FAULT      = 2;
  localparam int IRQ_ADDR_ERR   = 3;
  localparam int IRQ_W          = 4;

  // loop addressing
  localparam int          LOOP_ADDR_MAX    = 127;
  localparam int          LOOP_ADDR_DEV    = 126;
  localparam logic [6:0]  LOOP_ADDR_RESET  = 7'h7F;

  // activity indicator timing
  localparam longint CLK_HZ            = 100_000_000;
  localparam longint SLOW_PERIOD_MS    = 2000;
  localparam longint SLOW_ON_PCT       = 20;
  localparam longint STEADY_PERIOD_MS  = 1000;
  localparam longint TOGGLE_PERIOD_MS  = 250;
  localparam longint SLOW_PERIOD_CYC   = CLK_HZ / 1000 * SLOW_PERIOD_MS;
  localparam longint STEADY_PERIOD_CYC = CLK_HZ / 1000 * STEADY_PERIOD_MS;
  localparam longint TOGGLE_PERIOD_CYC = CLK_HZ / 1000 * TOGGLE_PERIOD_MS;

  typedef enum logic [1:0] {
    DSL_SPIN_STOPPED,
    DSL_SPIN_AT_SPEED,
    DSL_SPIN_CHANGING
  } dsl_spin_t;

  // drive conditions from the rest of the device
  typedef struct packed {
    dsl_spin_t  spin;
    logic       cmd_active;
    logic       format_active;
    logic       rewrite_active;
    logic       port_a_fail;
    logic       port_b_fail;
    logic       internal_fail;
  } dsl_drive_t;

  // per-port link failure reports
  typedef struct packed {
    logic wrap_fail;
    logic rx_clk_lost;
    logic tx_clk_lost;
    logic hw_error;
  } dsl_port_err_t;

  typedef enum logic [1:0] {
    DSL_W_IDLE,
    DSL_W_RESP
  } dsl_wstate_t;

endpackage

//--- core/dsl_status_led_bypass.sv
// Notes on behaviour
// - the fault indicator is driven when both loop ports have failed.
// - the fault indicator is driven when internal monitoring reports a drive failure.
// - the fault indicator is driven while the host fault-light command is set.
// - the fault indicator is an open-drain sink, pulling low when on, floating otherwise.
// - spindle stopped and idle gives a slow blink, 20% lit of a 2 s period.
// - spindle stopped with a command executing holds the activity indicator lit.
// - spindle at speed and idle holds the activity indicator lit.
// - spindle at speed with a command executing holds the activity indicator dark.
// - spindle accelerating or decelerating gives an even 50/50 blink.
// - format or repeated-block write in progress toggles the activity indicator.
// - each port has its own active-low bypass request that the backplane circuit obeys.
// - a port's bypass indicator goes low whenever that port's bypass request is asserted.
// - wrap test failure, lost receive or transmit clock or interface error asserts bypass.
// - option inputs are pulled high inside, open reads one and grounded reads zero.
// - at most 127 loop addresses with one reserved for the fabric, 126 usable.
module dsl_status_led_bypass
  import dsl_pkg::*;
#(
  parameter longint SLOW_CYC   = SLOW_PERIOD_CYC,
  parameter longint STEADY_CYC = STEADY_PERIOD_CYC,
  parameter longint TOGGLE_CYC = TOGGLE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // drive conditions, same clock
  input  wire dsl_drive_t           drive,
  input  wire dsl_port_err_t        port_a_err,
  input  wire dsl_port_err_t        port_b_err,
  // option strap pins, asynchronous
  input  wire logic                 device_option_bit2,
  input  wire logic                 device_option_bit1,
  input  wire logic                 device_option_bit0,
  // backplane outputs
  output logic                      fault_indicator_n_o,
  output logic                      fault_indicator_n_oe,
  output logic                      activity_indicator_n_o,
  output logic                      activity_indicator_n_oe,
  output logic                      bypass_port_a_n,
  output logic                      bypass_port_b_n,
  output logic                      bypass_led_a_n,
  output logic                      bypass_led_b_n,
  output logic                      irq
);

  typedef struct packed {
    logic [31:0]      ctrl;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [6:0]       loop_addr;
    logic [2:0]       opt_meta;
    logic [2:0]       opt_sync;
    logic [31:0]      cnt;
    logic             fault_on;
    logic             act_on;
    logic             byp_a;
    logic             byp_b;
    logic             byp_a_lat;
    logic             byp_b_lat;
    dsl_wstate_t      wstate;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } dsl_state_t;

  dsl_state_t r;
  dsl_state_t next_r;

  localparam logic [31:0] SLOW_C   = 32'(SLOW_CYC);
  localparam logic [31:0] SLOW_ON  = 32'(SLOW_CYC * SLOW_ON_PCT / 100);
  localparam logic [31:0] STEADY_C = 32'(STEADY_CYC);
  localparam logic [31:0] TOGGLE_C = 32'(TOGGLE_CYC);

  // lit while phase lies in the first 'on' cycles of a period
  function automatic logic phase_on(input logic [31:0] c, input logic [31:0] per,
                                    input logic [31:0] on);
    phase_on = (c % per) < on;
  endfunction

  function automatic logic port_failed(input dsl_port_err_t e);
    port_failed = e.wrap_fail | e.rx_clk_lost | e.tx_clk_lost | e.hw_error;
  endfunction

  logic       aw_take;
  logic       ar_take;
  logic       err_a;
  logic       err_b;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;
  logic [31:0] wmask;

  always_comb begin
    next_r = r;
    aw_take = (r.wstate == DSL_W_IDLE) && s_axi_awvalid && s_axi_wvalid;
    ar_take = !r.rvalid && s_axi_arvalid;
    wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    w1c = '0;
    ev = '0;

    // option straps: open reads one thanks to the pull-up
    next_r.opt_meta = {device_option_bit2, device_option_bit1, device_option_bit0};
    next_r.opt_sync = r.opt_meta;

    // free-running, so blink phase never restarts on a mode change
    next_r.cnt = r.cnt + 32'h0000_0001;

    // write channel: both address and data taken in the same edge
    case (r.wstate)
      DSL_W_IDLE: begin
        if (aw_take) begin
          next_r.wstate = DSL_W_RESP;
          next_r.bresp = RESP_OKAY;
          case (s_axi_awaddr)
            REG_CTRL: next_r.ctrl = (r.ctrl & ~wmask) | (s_axi_wdata & wmask);
            REG_IRQ_STATUS: w1c = s_axi_wdata[IRQ_W-1:0] & wmask[IRQ_W-1:0];
            REG_IRQ_MASK: begin
              next_r.irq_mask = (r.irq_mask & ~wmask[IRQ_W-1:0])
                              | (s_axi_wdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
            end
            REG_LOOP_ADDR: begin
              if (s_axi_wstrb[0]) begin
                // only 126 loop device addresses are usable
                if (s_axi_wdata[6:0] < 7'(LOOP_ADDR_DEV)) begin
                  next_r.loop_addr = s_axi_wdata[6:0];
                end else begin
                  next_r.loop_addr = LOOP_ADDR_RESET;
                  ev[IRQ_ADDR_ERR] = 1'b1;
                end
              end
            end
            REG_STATUS: next_r.bresp = RESP_OKAY;
            default: next_r.bresp = RESP_SLVERR;
          endcase
        end
      end
      DSL_W_RESP: begin
        if (s_axi_bready) begin
          next_r.wstate = DSL_W_IDLE;
        end
      end
      default: next_r.wstate = DSL_W_IDLE;
    endcase

    // read channel
    if (ar_take) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: next_r.rdata = r.ctrl;
        REG_STATUS: begin
          next_r.rdata = {20'h00000, r.opt_sync, 1'b0, r.act_on, r.fault_on,
                          r.byp_b, r.byp_a, r.wstate == DSL_W_RESP, 3'h0};
          next_r.rdata[1:0] = 2'h0;
        end
        REG_IRQ_STATUS: next_r.rdata = {28'h0000000, r.irq_status};
        REG_IRQ_MASK: next_r.rdata = {28'h0000000, r.irq_mask};
        REG_LOOP_ADDR: next_r.rdata = {25'h0000000, r.loop_addr};
        default: begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // bypass: a failure latches until software clears it; a force bit also asserts bypass
    err_a = port_failed(port_a_err);
    err_b = port_failed(port_b_err);
    next_r.byp_a_lat = err_a | (r.byp_a_lat & ~r.ctrl[CTRL_BYP_CLR_A]);
    next_r.byp_b_lat = err_b | (r.byp_b_lat & ~r.ctrl[CTRL_BYP_CLR_B]);
    next_r.byp_a = next_r.byp_a_lat | r.ctrl[CTRL_BYP_FORCE_A];
    next_r.byp_b = next_r.byp_b_lat | r.ctrl[CTRL_BYP_FORCE_B];
    // self-clearing clear bits
    next_r.ctrl[CTRL_BYP_CLR_A] = aw_take && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]
                                  && s_axi_wdata[CTRL_BYP_CLR_A];
    next_r.ctrl[CTRL_BYP_CLR_B] = aw_take && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]
                                  && s_axi_wdata[CTRL_BYP_CLR_B];

    // fault indicator
    next_r.fault_on = (drive.port_a_fail & drive.port_b_fail)
                    | drive.internal_fail
                    | r.ctrl[CTRL_FAULT_CMD];

    // activity pattern; format or rewrite takes precedence
    if (drive.format_active || drive.rewrite_active) begin
      next_r.act_on = phase_on(r.cnt, TOGGLE_C, TOGGLE_C >> 1);
    end else begin
      case (drive.spin)
        DSL_SPIN_STOPPED: begin
          if (drive.cmd_active) begin
            next_r.act_on = 1'b1;
          end else begin
            next_r.act_on = phase_on(r.cnt, SLOW_C, SLOW_ON);
          end
        end
        DSL_SPIN_AT_SPEED: next_r.act_on = !drive.cmd_active;
        DSL_SPIN_CHANGING: next_r.act_on = phase_on(r.cnt, STEADY_C, STEADY_C >> 1);
        default: next_r.act_on = 1'b0;
      endcase
    end

    // sticky events on rising edges; set wins over a same-cycle clear
    ev[IRQ_BYPASS_A] = next_r.byp_a & ~r.byp_a;
    ev[IRQ_BYPASS_B] = next_r.byp_b & ~r.byp_b;
    ev[IRQ_FAULT] = next_r.fault_on & ~r.fault_on;
    next_r.irq_status = (r.irq_status & ~w1c) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ctrl <= CTRL_RESET;
      r.loop_addr <= LOOP_ADDR_RESET;
      r.opt_meta <= 3'h7;
      r.opt_sync <= 3'h7;
      r.wstate <= DSL_W_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready = aw_take;
  assign s_axi_bvalid = (r.wstate == DSL_W_RESP);
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = ar_take;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  // open drain: enable low while sinking, output held low
  assign fault_indicator_n_o = 1'b0;
  assign fault_indicator_n_oe = !r.fault_on;
  assign activity_indicator_n_o = 1'b0;
  assign activity_indicator_n_oe = !r.act_on;
  assign bypass_port_a_n = !r.byp_a;
  assign bypass_port_b_n = !r.byp_b;
  assign bypass_led_a_n = !r.byp_a;
  assign bypass_led_b_n = !r.byp_b;
  assign irq = |(r.irq_status & r.irq_mask);

endmodule

//--- bench/dsl_status_led_bypass_checker.sv
module dsl_status_led_bypass_checker
  import dsl_pkg::*;
(
  // clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // drive conditions
  input wire dsl_drive_t    drive,
  input wire dsl_port_err_t port_a_err,
  input wire dsl_port_err_t port_b_err,
  // backplane outputs
  input wire logic          fault_indicator_n_o,
  input wire logic          fault_indicator_n_oe,
  input wire logic          activity_indicator_n_oe,
  input wire logic          bypass_port_a_n,
  input wire logic          bypass_port_b_n,
  input wire logic          bypass_led_a_n,
  input wire logic          bypass_led_b_n
);
  // format or rewrite overrides the spindle patterns, so those checks need it off
  logic quiet;
  assign quiet = !drive.format_active && !drive.rewrite_active;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fault_ports; drive.port_a_fail && drive.port_b_fail |=> !fault_indicator_n_oe; endproperty
  a_fault_ports: assert property (p_fault_ports) else $error("fault dark on two ports");
  property p_fault_int; drive.internal_fail |=> !fault_indicator_n_oe; endproperty
  a_fault_int: assert property (p_fault_int) else $error("fault dark on internal");
  property p_sink; !fault_indicator_n_oe |-> !fault_indicator_n_o; endproperty
  a_sink: assert property (p_sink) else $error("fault sink not low");
  property p_led; bypass_led_a_n == bypass_port_a_n && bypass_led_b_n == bypass_port_b_n; endproperty
  a_led: assert property (p_led) else $error("bypass led differs");
  property p_byp_a; |port_a_err |=> !bypass_port_a_n; endproperty
  a_byp_a: assert property (p_byp_a) else $error("port a not bypassed");
  property p_byp_b; |port_b_err |=> !bypass_port_b_n; endproperty
  a_byp_b: assert property (p_byp_b) else $error("port b not bypassed");
  property p_stop_cmd; drive.spin == DSL_SPIN_STOPPED && drive.cmd_active && quiet
    |=> !activity_indicator_n_oe; endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("activity dark stopped busy");
  property p_up_idle; drive.spin == DSL_SPIN_AT_SPEED && !drive.cmd_active && quiet
    |=> !activity_indicator_n_oe; endproperty
  a_up_idle: assert property (p_up_idle) else $error("activity dark at speed idle");
  property p_up_cmd; drive.spin == DSL_SPIN_AT_SPEED && drive.cmd_active && quiet
    |=> activity_indicator_n_oe; endproperty
  a_up_cmd: assert property (p_up_cmd) else $error("activity lit at speed busy");
endmodule

//--- bench/dsl_backplane_model.sv
module dsl_backplane_model (
  // drive connector outputs
  input  wire logic       fault_indicator_n_o,
  input  wire logic       fault_indicator_n_oe,
  input  wire logic       activity_indicator_n_o,
  input  wire logic       activity_indicator_n_oe,
  input  wire logic       bypass_port_a_n,
  input  wire logic       bypass_port_b_n,
  // strap switches, a one grounds the pin
  input  wire logic [2:0] strap_gnd,
  // backplane state
  output logic            fault_lit,
  output logic            activity_lit,
  output logic            loop_bypassed_a,
  output logic            loop_bypassed_b,
  output logic            device_option_bit2,
  output logic            device_option_bit1,
  output logic            device_option_bit0
);
  // the led anode pulls a released line high, so the led stays dark
  assign fault_lit = !(fault_indicator_n_oe | fault_indicator_n_o);
  assign activity_lit = !(activity_indicator_n_oe | activity_indicator_n_o);
  assign loop_bypassed_a = !bypass_port_a_n;
  assign loop_bypassed_b = !bypass_port_b_n;
  // an open strap reads one through the pull-up inside the drive
  assign {device_option_bit2, device_option_bit1, device_option_bit0} = ~strap_gnd;
endmodule

//--- bench/tb_dsl_status_led_bypass.sv
`define CHK(what, exp, got) \
  begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", what, exp, got); end end
module tb_dsl_status_led_bypass;
  import dsl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic          s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic          s_axi_rvalid, fault_indicator_n_o, fault_indicator_n_oe, irq, fault_lit;
  logic          activity_indicator_n_o, activity_indicator_n_oe, bypass_port_a_n;
  logic          bypass_port_b_n, bypass_led_a_n, bypass_led_b_n, activity_lit;
  logic          loop_bypassed_a, loop_bypassed_b, device_option_bit2, device_option_bit1;
  logic          device_option_bit0;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]    s_axi_wstrb, e;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]    strap_gnd;
  dsl_drive_t    drive;
  dsl_port_err_t port_a_err, port_b_err;
  int            miscompares, num_checks, n;

  // short blink periods keep the run brief
  dsl_status_led_bypass #(.SLOW_CYC(100), .STEADY_CYC(50), .TOGGLE_CYC(20)) uut (.*);
  dsl_backplane_model bp (.*);

  always #5 aclk = ~aclk;

  task automatic results;
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do @(negedge aclk); while (!(s_axi_awready === 1'h1 && s_axi_wready === 1'h1));
    @(posedge aclk);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
  endtask

  task automatic drv(input logic [7:0] d, input logic [3:0] ea, input logic [3:0] eb);
    @(posedge aclk);
    drive <= d;
    port_a_err <= ea;
    port_b_err <= eb;
    settle();
  endtask

  // count lit cycles over one whole pattern period
  task automatic act(input dsl_spin_t s, input logic [2:0] cfw, input int cyc, input int exp);
    drv({s, cfw, 3'h0}, 4'h0, 4'h0);
    n = 0;
    repeat (cyc) begin
      @(posedge aclk);
      #1;
      n += activity_lit;
    end
    `CHK("activity lit count", exp, n)
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    results();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, strap_gnd} = '0;
    {drive, port_a_err, port_b_err} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rdr(REG_LOOP_ADDR);
    `CHK("loop addr reset", 32'h7F, rd)
    rdr(REG_STATUS);
    `CHK("options open", 3'h7, rd[11:9])
    strap_gnd <= 3'h2;
    rdr(8'h40);
    `CHK("unmapped resp", RESP_SLVERR, rsp)
    rdr(REG_STATUS);
    `CHK("option grounded", 3'h5, rd[11:9])
    wr(REG_LOOP_ADDR, 32'h7E);
    rdr(REG_LOOP_ADDR);
    `CHK("loop addr refused", 32'h7F, rd)
    rdr(REG_IRQ_STATUS);
    `CHK("loop addr event", 1'h1, rd[IRQ_ADDR_ERR])
    wr(REG_LOOP_ADDR, 32'h7D);
    rdr(REG_LOOP_ADDR);
    `CHK("loop addr top", 32'h7D, rd)
    drv(8'h04, 4'h0, 4'h0);
    `CHK("fault one port", 1'h0, fault_lit)
    drv(8'h06, 4'h0, 4'h0);
    `CHK("fault two ports", 1'h1, fault_lit)
    drv(8'h01, 4'h0, 4'h0);
    `CHK("fault internal", 1'h1, fault_lit)
    drv(8'h00, 4'h0, 4'h0);
    wr(REG_CTRL, 32'h1);
    settle();
    `CHK("fault command", 1'h1, fault_lit)
    wr(REG_CTRL, 32'h0);
    settle();
    `CHK("fault command off", 1'h0, fault_lit)
    // every failure kind on each port, irq masked on alternate passes
    for (int i = 0; i < 8; i++) begin
      e = 4'h1 << i[1:0];
      wr(REG_IRQ_MASK, i[0] ? 32'h3 : 32'h0);
      drv(8'h00, i[2] ? 4'h0 : e, i[2] ? e : 4'h0);
      `CHK("bypassed", 1'h1, i[2] ? loop_bypassed_b : loop_bypassed_a)
      `CHK("bypass led", 1'h0, bypass_led_a_n & bypass_led_b_n)
      `CHK("irq raised", i[0], irq)
      rdr(REG_STATUS);
      `CHK("bypass status", i[2] ? 2'h2 : 2'h1, rd[5:4])
      drv(8'h00, 4'h0, 4'h0);
      wr(REG_CTRL, i[2] ? 32'h10 : 32'h08);
      wr(REG_IRQ_STATUS, i[2] ? 32'h2 : 32'h1);
      settle();
      `CHK("bypass released", 1'h0, loop_bypassed_a | loop_bypassed_b)
      `CHK("irq cleared", 1'h0, irq)
    end
    act(DSL_SPIN_STOPPED, 3'h0, 100, 20);
    act(DSL_SPIN_STOPPED, 3'h4, 100, 100);
    act(DSL_SPIN_AT_SPEED, 3'h0, 100, 100);
    act(DSL_SPIN_AT_SPEED, 3'h4, 100, 0);
    act(DSL_SPIN_CHANGING, 3'h0, 50, 25);
    act(DSL_SPIN_AT_SPEED, 3'h6, 20, 10);
    act(DSL_SPIN_STOPPED, 3'h1, 20, 10);
    results();
  end
endmodule

bind dsl_status_led_bypass dsl_status_led_bypass_checker chk (.*);
